// File: verilog/wcp_top.sv
// wetting level and pulsed-cleaning configuration bank with activation timer
// assumes the serial engine presents single-cycle read/write strobes on clk_in
`default_nettype none

module wcp_top #(
  parameter int unsigned PULSE_UNIT_CYCLES = wcp_pkg::PULSE_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register port from the serial engine
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [5:0] addr_in,
  input wire logic [23:0] wr_data_in,
  output logic [23:0] rd_data_out,
  output logic rd_valid_out,
  // pulse request from the sampling sequencer
  input wire logic pulse_start_in,
  output logic pulse_active_out,
  // controls to the analog current sources
  output logic [29:0] wet_level_pair_out,
  output logic [23:0] pulse_level_group_out,
  output logic [23:0] pulse_enable_out,
  output logic [23:0] pulse_drive_out
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // a zero unit would wrap UNIT_LAST to 16'hffff and stretch every slot to 65536 cycles
  // the unit counter is only UNIT_CNT_W bits wide
  if (PULSE_UNIT_CYCLES < 1 || PULSE_UNIT_CYCLES >= (1 << wcp_pkg::UNIT_CNT_W)) begin : g_bad
    $error("PULSE_UNIT_CYCLES out of range");
  end

  localparam logic [15:0] UNIT_LAST = 16'(PULSE_UNIT_CYCLES - 1);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [23:0] wet_upper_reg, wet_upper_next;
  logic [23:0] pulse_cfg_reg, pulse_cfg_next;
  logic [23:0] pulse_en_reg, pulse_en_next;
  logic [23:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;

  always_comb begin
    wet_upper_next = wet_upper_reg;
    pulse_cfg_next = pulse_cfg_reg;
    pulse_en_next = pulse_en_reg;
    // offsets of other blocks fall to default and are ignored here
    if (wr_en_in) begin
      case (addr_in)
        wcp_pkg::ADDR_WET_UPPER: wet_upper_next = wr_data_in & wcp_pkg::WET_UPPER_MASK;
        wcp_pkg::ADDR_PULSE_CFG: pulse_cfg_next = wr_data_in & wcp_pkg::PULSE_CFG_MASK;
        wcp_pkg::ADDR_PULSE_EN: pulse_en_next = wr_data_in & wcp_pkg::PULSE_EN_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path, answered the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_valid_next = rd_en_in;
    // both strobes in one cycle: the read returns the old value
    if (rd_en_in) begin
      case (addr_in)
        wcp_pkg::ADDR_WET_UPPER: rd_data_next = wet_upper_reg & wcp_pkg::WET_UPPER_MASK;
        wcp_pkg::ADDR_PULSE_CFG: rd_data_next = pulse_cfg_reg & wcp_pkg::PULSE_CFG_MASK;
        wcp_pkg::ADDR_PULSE_EN: rd_data_next = pulse_en_reg;
        // unmapped here: reads zero
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wet_upper_reg <= wcp_pkg::WET_UPPER_RESET;
      pulse_cfg_reg <= wcp_pkg::PULSE_CFG_RESET;
      pulse_en_reg <= wcp_pkg::PULSE_EN_RESET;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      wet_upper_reg <= wet_upper_next;
      pulse_cfg_reg <= pulse_cfg_next;
      pulse_en_reg <= pulse_en_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ----------------------------------------------------------------
  // level decode
  // ----------------------------------------------------------------
  // decode is combinational; the output flops below absorb its delay
  wcp_cfg_if cfg_bus ();

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      // pair i field at bits 3i+2..3i
      cfg_bus.wet_code[i] = wet_upper_reg[wcp_pkg::WET_PAIR_LSB + i * wcp_pkg::WET_FIELD_W +: 3];
    end
    cfg_bus.group_15ma = pulse_cfg_reg[wcp_pkg::PULSE_GRP_LSB +: 4];
  end

  wcp_level_decode u_decode (
    .cfg (cfg_bus.dec)
  );

  // ----------------------------------------------------------------
  // pulsed activation timer
  // ----------------------------------------------------------------
  // time code is latched at start so a write mid-pulse cannot stretch it
  // starts while active are dropped with no indication
  wcp_pkg::wcp_state_t state_reg, state_next;
  logic [15:0] unit_cnt_reg, unit_cnt_next;
  logic [2:0] slot_cnt_reg, slot_cnt_next;

  always_comb begin
    state_next = state_reg;
    unit_cnt_next = unit_cnt_reg;
    slot_cnt_next = slot_cnt_reg;
    case (state_reg)
      wcp_pkg::WCP_IDLE: begin
        if (pulse_start_in) begin
          state_next = wcp_pkg::WCP_ACTIVE;
          unit_cnt_next = UNIT_LAST;
          slot_cnt_next = pulse_cfg_reg[wcp_pkg::PULSE_TIME_LSB +: 3];
        end
      end
      wcp_pkg::WCP_ACTIVE: begin
        if (unit_cnt_reg != '0) begin
          unit_cnt_next = unit_cnt_reg - 16'h0001;
        end else if (slot_cnt_reg != '0) begin
          // one slot is UNIT_LAST+1 edges, so code+1 slots make the full time
          unit_cnt_next = UNIT_LAST;
          slot_cnt_next = slot_cnt_reg - 3'h1;
        end else begin
          state_next = wcp_pkg::WCP_IDLE;
        end
      end
      default: state_next = wcp_pkg::WCP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= wcp_pkg::WCP_IDLE;
      unit_cnt_reg <= '0;
      slot_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      unit_cnt_reg <= unit_cnt_next;
      slot_cnt_reg <= slot_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // registered analog controls
  // ----------------------------------------------------------------
  logic [29:0] wet_level_reg, wet_level_next;
  logic [23:0] group_level_reg, group_level_next;
  logic [23:0] drive_reg, drive_next;
  logic active_reg, active_next;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      wet_level_next[i * 6 +: 6] = cfg_bus.wet_onehot[i];
    end
    for (int g = 0; g < 4; g++) begin
      group_level_next[g * 6 +: 6] = cfg_bus.group_onehot[g];
    end
    active_next = (state_next == wcp_pkg::WCP_ACTIVE);
    // next enables, so an enable write mid-pulse lands with the register
    // only enabled inputs get pulse current
    drive_next = active_next ? pulse_en_next : '0;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wet_level_reg <= '0;
      group_level_reg <= '0;
      drive_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      wet_level_reg <= wet_level_next;
      group_level_reg <= group_level_next;
      drive_reg <= drive_next;
      active_reg <= active_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flop; the assigns only rename
  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign pulse_active_out = active_reg;
  assign wet_level_pair_out = wet_level_reg;
  assign pulse_level_group_out = group_level_reg;
  assign pulse_enable_out = pulse_en_reg;
  assign pulse_drive_out = drive_reg;

endmodule

`default_nettype wire

// File: include/wcp_pkg.sv
// wetting current and pulsed-cleaning configuration: shared constants and decode
// assumes one 20 MHz clock and a parallel register port from the serial engine
//
// Overview of operation
// - 3-bit code: 0,1,2,5,10mA; 5-7 give 15mA
// - upper pair fields at bits 14-0, read/write
// - activation time is 64us times code plus one
// - bit 3 selects 10/15mA for inputs 18-23
// - bit 2 selects 10/15mA for inputs 12-17
// - bit 1 selects 10/15mA for inputs 6-11
// - bit 0 selects 10/15mA for inputs 0-5
// - pulse config bits 23-7 read as zero
// - pulse config resets to zero
// - 24 per-input enable bits, reset zero
// - enable bit set activates that input's pulse
`default_nettype none

package wcp_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 24;
  localparam logic [5:0] ADDR_WET_UPPER = 6'h1e;
  localparam logic [5:0] ADDR_PULSE_CFG = 6'h1f;
  localparam logic [5:0] ADDR_PULSE_EN = 6'h20;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned WET_FIELD_W = 3;
  localparam int unsigned WET_PAIRS = 5;
  localparam int unsigned WET_PAIR_LSB = 0;
  localparam int unsigned PULSE_TIME_LSB = 4;
  localparam int unsigned PULSE_TIME_W = 3;
  localparam int unsigned PULSE_GRP_LSB = 0;
  localparam int unsigned PULSE_GROUPS = 4;
  localparam int unsigned GROUP_INPUTS = 6;
  localparam int unsigned NUM_INPUTS = 24;
  localparam logic [23:0] WET_UPPER_MASK = 24'h007fff;
  localparam logic [23:0] PULSE_CFG_MASK = 24'h00007f;
  localparam logic [23:0] PULSE_EN_MASK = 24'hffffff;
  localparam logic [23:0] WET_UPPER_RESET = 24'h000000;
  localparam logic [23:0] PULSE_CFG_RESET = 24'h000000;
  localparam logic [23:0] PULSE_EN_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // current levels, one-hot control to the analog sources
  // ----------------------------------------------------------------
  localparam int unsigned LVL_W = 6;
  localparam int unsigned LVL_OFF = 0;
  localparam int unsigned LVL_1MA = 1;
  localparam int unsigned LVL_2MA = 2;
  localparam int unsigned LVL_5MA = 3;
  localparam int unsigned LVL_10MA = 4;
  localparam int unsigned LVL_15MA = 5;
  localparam logic [2:0] CODE_10MA = 3'h4;
  localparam logic [2:0] CODE_15MA = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PULSE_UNIT_NS = 64000;
  // least time, so round up
  localparam int unsigned PULSE_UNIT_CYCLES = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UNIT_CNT_W = 16;

  typedef enum logic [0:0] {
    WCP_IDLE,
    WCP_ACTIVE
  } wcp_state_t;

  function automatic logic [5:0] wcp_wet_decode(input logic [2:0] code);
    logic [5:0] lvl;
    lvl = '0;
    case (code)
      3'h0: lvl[LVL_OFF] = 1'b1;
      3'h1: lvl[LVL_1MA] = 1'b1;
      3'h2: lvl[LVL_2MA] = 1'b1;
      3'h3: lvl[LVL_5MA] = 1'b1;
      3'h4: lvl[LVL_10MA] = 1'b1;
      default: lvl[LVL_15MA] = 1'b1;
    endcase
    return lvl;
  endfunction

endpackage

`default_nettype wire

// File: include/wcp_cfg_if.sv
// carries register fields to the level decoder and decoded levels back
// assumes both ends sit in the same clock domain, purely combinational path
`default_nettype none

interface wcp_cfg_if;
  logic [4:0][2:0] wet_code;
  logic [3:0] group_15ma;
  logic [4:0][5:0] wet_onehot;
  logic [3:0][5:0] group_onehot;

  modport regs (output wet_code, output group_15ma, input wet_onehot, input group_onehot);
  modport dec (input wet_code, input group_15ma, output wet_onehot, output group_onehot);
endinterface

`default_nettype wire

// File: verilog/wcp_level_decode.sv
// decodes stored level fields into one-hot current source controls
// assumes codes come straight from the register flops; output is combinational
`default_nettype none

module wcp_level_decode (
  wcp_cfg_if.dec cfg
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      cfg.wet_onehot[i] = wcp_pkg::wcp_wet_decode(cfg.wet_code[i]);
    end
    for (int g = 0; g < 4; g++) begin
      cfg.group_onehot[g] = wcp_pkg::wcp_wet_decode(
        cfg.group_15ma[g] ? wcp_pkg::CODE_15MA : wcp_pkg::CODE_10MA);
    end
  end

endmodule

`default_nettype wire

// File: verif/wcp_top_assertions.sv
// checker for the configuration bank, top ports only
// assumes bind into wcp_top with the pulse unit count handed on
`default_nettype none
module wcp_assertions #(
  parameter int unsigned PULSE_UNIT_CYCLES = 2
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [5:0] addr_in,
  input wire logic [23:0] wr_data_in,
  input wire logic [23:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic pulse_start_in,
  input wire logic pulse_active_out,
  input wire logic [29:0] wet_level_pair_out,
  input wire logic [23:0] pulse_level_group_out,
  input wire logic [23:0] pulse_enable_out,
  input wire logic [23:0] pulse_drive_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // counts active cycles so the length is judged when the pulse ends
  logic [15:0] run_reg;
  logic [15:0] run_next;
  always_comb begin
    run_next = pulse_active_out ? run_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_reg <= 16'h0;
    end else begin
      run_reg <= run_next;
    end
  end
  a_read_answer: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  a_read_quiet: assert property (!rd_en_in |=> !rd_valid_out)
    else $error("read answer without request");
  a_read_hold: assert property (!rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved without read");
  a_cfg_reserved: assert property (rd_valid_out && $past(addr_in) == 6'h1f
    |-> rd_data_out[23:7] == 17'h0) else $error("reserved bits not zero");
  a_drive_idle: assert property (!pulse_active_out |-> pulse_drive_out == 24'h0)
    else $error("drive while idle");
  a_drive_follow: assert property (pulse_active_out && $stable(pulse_enable_out)
    |-> pulse_drive_out == pulse_enable_out) else $error("drive differs from enables");
  a_pulse_rise: assert property (pulse_start_in && !pulse_active_out |=> pulse_active_out)
    else $error("pulse did not start");
  a_pulse_len: assert property ($fell(pulse_active_out) |-> run_reg >= PULSE_UNIT_CYCLES
    && run_reg <= 8 * PULSE_UNIT_CYCLES) else $error("pulse length out of range");
  a_level_onehot: assert property ($past(reset_n_in) |-> $onehot(wet_level_pair_out[29:24])
    && $onehot(pulse_level_group_out[23:18]) && pulse_level_group_out[21:18] == 4'h0)
    else $error("level control not one-hot");
  cover property (rd_valid_out && $past(addr_in) == 6'h1f);
  cover property ($fell(pulse_active_out));
  cover property (wet_level_pair_out[5]);
endmodule
bind wcp_top wcp_assertions #(.PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)) u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .pulse_start_in(pulse_start_in),
  .pulse_active_out(pulse_active_out), .wet_level_pair_out(wet_level_pair_out),
  .pulse_level_group_out(pulse_level_group_out), .pulse_enable_out(pulse_enable_out),
  .pulse_drive_out(pulse_drive_out));
`default_nettype wire

// File: verif/wcp_top_tb_top.sv
// self-checking bench for the configuration bank and pulse timer
// assumes the pulse unit is shrunk to two cycles to keep the run short
`default_nettype none
module wcp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned N = 2;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic pulse_start_in = 1'b0;
  logic [5:0] addr_in = 6'h0;
  logic [23:0] wr_data_in = 24'h0;
  logic [23:0] rd_data_out, pulse_level_group_out, pulse_enable_out, pulse_drive_out;
  logic rd_valid_out, pulse_active_out;
  logic [29:0] wet_level_pair_out;
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk_in = ~clk_in;
  wcp_top #(.PULSE_UNIT_CYCLES(N)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .pulse_start_in(pulse_start_in),
    .pulse_active_out(pulse_active_out), .wet_level_pair_out(wet_level_pair_out),
    .pulse_level_group_out(pulse_level_group_out), .pulse_enable_out(pulse_enable_out),
    .pulse_drive_out(pulse_drive_out));
  task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    @(posedge clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    chk("read valid", 30'h1, {29'h0, rd_valid_out});
    chk("read data", {6'h0, e}, {6'h0, rd_data_out});
  endtask
  function automatic logic [5:0] lvl(input logic [2:0] c);
    return (c < 3'h5) ? (6'h01 << c) : 6'h20;
  endfunction
  // hold 1 keeps the start up into the active time, where it must be ignored
  task automatic pulse(input logic [2:0] code, input int hold, input logic [23:0] en);
    int n;
    n = 0;
    wr(6'h1f, {17'h0, code, 4'h0});
    @(posedge clk_in);
    pulse_start_in <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      if (i == hold) begin
        pulse_start_in <= 1'b0;
      end
      #1;
      if (pulse_active_out !== 1'b1) begin
        break;
      end
      n++;
      chk("drive", {6'h0, en}, {6'h0, pulse_drive_out});
    end
    pulse_start_in <= 1'b0;
    chk("pulse length", 30'((code + 1) * N), 30'(n));
    chk("drive idle", 30'h0, {6'h0, pulse_drive_out});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    logic [23:0] exp;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("wet reset", {5{6'h01}}, wet_level_pair_out);
    chk("group reset", {6'h0, {4{6'h10}}}, {6'h0, pulse_level_group_out});
    rd(6'h1f, 24'h0);
    rd(6'h20, 24'h0);
    $display("test reset done");
    wr(6'h1e, 24'hffc688);
    rd(6'h1e, 24'h004688);
    chk("wet pairs", {6'h10, 6'h08, 6'h04, 6'h02, 6'h01}, wet_level_pair_out);
    for (int c = 0; c < 8; c++) begin
      wr(6'h1e, {9'h0, {5{3'(c)}}});
      rd(6'h1e, {9'h0, {5{3'(c)}}});
      chk("wet decode", {5{lvl(3'(c))}}, wet_level_pair_out);
    end
    $display("test wet levels done");
    wr(6'h1f, 24'hffffff);
    rd(6'h1f, 24'h00007f);
    for (int g = 0; g < 4; g++) begin
      wr(6'h1f, 24'(1 << g));
      rd(6'h1f, 24'(1 << g));
      exp = {4{6'h10}};
      exp[g * 6 +: 6] = 6'h20;
      chk("group level", {6'h0, exp}, {6'h0, pulse_level_group_out});
    end
    $display("test pulse config done");
    wr(6'h20, 24'h5a5a5a);
    wr(6'h3f, 24'hffffff);
    rd(6'h3f, 24'h000000);
    rd(6'h20, 24'h5a5a5a);
    chk("enable out", {6'h0, 24'h5a5a5a}, {6'h0, pulse_enable_out});
    pulse(3'h0, 0, 24'h5a5a5a);
    pulse(3'h7, 1, 24'h5a5a5a);
    wr(6'h20, 24'h0);
    pulse(3'h2, 0, 24'h0);
    $display("test pulse timing done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
